// File: adc_ctl_pkg.sv
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RES_W  = 10;
  localparam int ADDR_W = 4;
  localparam int CNT_W  = 4;
  localparam int CONV_W = 10;

  // ----------------------------------------------------------------
  // shift-clock edge positions (count of edges already seen)
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] RISE_ADDR_LAST = 4'h3;  // 4th rising edge
  localparam logic [CNT_W-1:0] RISE_LONG      = 4'hA;  // 11th rising edge
  localparam logic [CNT_W-1:0] RISE_WRAP      = 4'hF;  // 16th rising edge
  localparam logic [CNT_W-1:0] FALL_SAMPLE    = 4'h3;  // 4th falling edge
  localparam logic [CNT_W-1:0] FALL_TENTH     = 4'h9;  // 10th falling edge
  localparam logic [CNT_W-1:0] FALL_WRAP      = 4'hF;  // 16th falling edge
  localparam logic [CNT_W-1:0] BITS_SHIFTED   = 4'hA;  // result bits per frame
  localparam logic [CNT_W-1:0] CNT_ONE        = 4'h1;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS  = 20000;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYC - 1);
  localparam logic [CONV_W-1:0] CONV_ONE  = 10'h001;

  // ----------------------------------------------------------------
  // channel codes and self-test results
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CODE_EXT_LAST = 4'hA;
  localparam logic [ADDR_W-1:0] CODE_TST_MID  = 4'hB;
  localparam logic [ADDR_W-1:0] CODE_TST_LOW  = 4'hC;
  localparam logic [ADDR_W-1:0] CODE_TST_HIGH = 4'hD;
  localparam logic [RES_W-1:0]  RES_MID       = 10'h200;
  localparam logic [RES_W-1:0]  RES_LOW       = 10'h000;
  localparam logic [RES_W-1:0]  RES_HIGH      = 10'h3FF;
  localparam logic [RES_W-1:0]  RES_RESET     = 10'h000;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } conv_st_t;

endpackage

// File: addr_capture.sv
module addr_capture
  import adc_ctl_pkg::*;
(
  // link
  input  wire logic              sclk,
  input  wire logic              link_rst_b,
  input  wire logic              addr_in,
  // status
  output logic [ADDR_W-1:0]      addr_q,
  output logic                   long_q
);

  typedef struct packed {
    logic [CNT_W-1:0]  rcnt;
    logic [ADDR_W-1:0] addr;
    logic              long_xfer;
  } cap_t;

  cap_t st_ff;
  cap_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rcnt = st_ff.rcnt + CNT_ONE;
    // msb first, later edges ignored until the frame restarts
    if (st_ff.rcnt <= RISE_ADDR_LAST) begin
      nxt_st.addr = {st_ff.addr[ADDR_W-2:0], addr_in};
    end
    if (st_ff.rcnt == RISE_LONG) begin
      nxt_st.long_xfer = 1'b1;
    end
    if (st_ff.rcnt == RISE_WRAP) begin
      nxt_st.long_xfer = 1'b0;
    end
  end

  // chip select high holds this in reset, so the pins are ignored
  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign addr_q = st_ff.addr;
  assign long_q = st_ff.long_xfer;

endmodule

// File: adc_serial_ctl.sv
module adc_serial_ctl
  import adc_ctl_pkg::*;
(
  // system
  input  wire logic              clk,
  input  wire logic              rst_b,
  // serial link
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              addr_in,
  output logic                   data_out,
  output logic                   data_oe,
  // converter core
  input  wire logic [RES_W-1:0]  conv_code,
  output logic                   eoc,
  output logic                   sample_en,
  output logic [ADDR_W-1:0]      chan_sel,
  output logic                   chan_valid
);

  // ----------------------------------------------------------------
  // link-side state, falling edges of the shift clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] fcnt;
    logic             past_ten;
    logic             wrapped;
    logic             sample;
  } link_t;

  // ----------------------------------------------------------------
  // system-side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              go_s1;
    logic              go_s2;
    logic              go_seen;
    logic              lg_s1;
    logic              lg_s2;
    logic              oe;
    logic              eoc;
    logic              restart;
    conv_st_t          state;
    logic [CONV_W-1:0] ccnt;
    logic [ADDR_W-1:0] chan;
    logic              chan_ok;
    logic [RES_W-1:0]  result;
  } sys_t;

  link_t             lk_ff;
  link_t             nxt_lk;
  sys_t              sy_ff;
  sys_t              nxt_sy;
  logic              go_tog_ff;
  logic              link_rst_b;
  logic [ADDR_W-1:0] link_addr;
  logic              link_long;
  logic [CNT_W-1:0]  bit_sel;
  logic              zero_out;
  logic              msb_ready;
  logic [ADDR_W-1:0] start_addr_ff;

  // ----------------------------------------------------------------
  // link reset
  // ----------------------------------------------------------------
  // the shift clock may stand still between frames, so a new frame
  // is opened asynchronously: by chip select high, or by a restart
  // pulse when select stays low through a fast conversion
  assign link_rst_b = ~(cs_n | sy_ff.restart);

  addr_capture u_addr (
    .sclk       (sclk),
    .link_rst_b (link_rst_b),
    .addr_in    (addr_in),
    .addr_q     (link_addr),
    .long_q     (link_long)
  );

  // ----------------------------------------------------------------
  // falling-edge sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_lk      = lk_ff;
    nxt_lk.fcnt = lk_ff.fcnt + CNT_ONE;
    // first fall after a 16-clock wrap starts the next frame
    if (lk_ff.wrapped) begin
      nxt_lk.past_ten = 1'b0;
      nxt_lk.wrapped  = 1'b0;
    end
    if (lk_ff.fcnt == FALL_SAMPLE) begin
      nxt_lk.sample = 1'b1;
    end
    if (lk_ff.fcnt == FALL_TENTH) begin
      nxt_lk.sample   = 1'b0;
      nxt_lk.past_ten = 1'b1;
    end
    if (lk_ff.fcnt == FALL_WRAP) begin
      nxt_lk.wrapped = 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // start request; not cleared by select, or a rise of select after
  // the tenth edge would look like a second start
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      go_tog_ff     <= 1'b0;
      start_addr_ff <= '0;
    end else if (link_rst_b && lk_ff.fcnt == FALL_TENTH) begin
      go_tog_ff     <= ~go_tog_ff;
      // held with the toggle: a select rise just after the tenth
      // edge clears the capture register before the start is seen
      start_addr_ff <= link_addr;
    end
  end

  // ----------------------------------------------------------------
  // serial result output
  // ----------------------------------------------------------------
  // a mux after flip-flops: the msb must appear with no shift-clock
  // edge at all (select fall, conversion-done rise)
  assign bit_sel  = (lk_ff.fcnt < BITS_SHIFTED) ? lk_ff.fcnt : '0;
  // eoc alone is still high for a few clocks after the tenth edge;
  // after a wrap the msb waits for the conversion this frame began
  assign msb_ready = lk_ff.wrapped && sy_ff.eoc && (go_tog_ff == sy_ff.go_seen);
  assign zero_out  = (lk_ff.past_ten && !msb_ready)
                     || (lk_ff.fcnt >= BITS_SHIFTED);

  always_comb begin
    data_out = 1'b0;
    if (!zero_out) begin
      data_out = sy_ff.result[CNT_W'(RES_W - 1) - bit_sel];
    end
  end

  // ----------------------------------------------------------------
  // system-side control and conversion timer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sy         = sy_ff;
    nxt_sy.cs_s1   = cs_n;
    nxt_sy.cs_s2   = sy_ff.cs_s1;
    nxt_sy.go_s1   = go_tog_ff;
    nxt_sy.go_s2   = sy_ff.go_s1;
    nxt_sy.lg_s1   = link_long;
    nxt_sy.lg_s2   = sy_ff.lg_s1;
    nxt_sy.restart = 1'b0;
    // a start seen while converting is dropped, not queued
    nxt_sy.go_seen = sy_ff.go_s2;
    nxt_sy.oe      = ~sy_ff.cs_s2;
    unique case (sy_ff.state)
      ST_IDLE: begin
        if (sy_ff.go_s2 != sy_ff.go_seen) begin
          // address held since the tenth falling edge
          nxt_sy.state   = ST_CONV;
          nxt_sy.eoc     = 1'b0;
          nxt_sy.ccnt    = '0;
          nxt_sy.chan    = start_addr_ff;
          nxt_sy.chan_ok = (start_addr_ff <= CODE_TST_HIGH);
        end
      end
      ST_CONV: begin
        nxt_sy.ccnt = sy_ff.ccnt + CONV_ONE;
        if (sy_ff.ccnt == CONV_LAST) begin
          nxt_sy.state = ST_IDLE;
          nxt_sy.eoc   = 1'b1;
          // idle link with select low: present the new msb now
          nxt_sy.restart = ~sy_ff.cs_s2 & ~sy_ff.lg_s2;
          if (sy_ff.chan <= CODE_EXT_LAST) begin
            nxt_sy.result = conv_code;
          end else if (sy_ff.chan == CODE_TST_MID) begin
            nxt_sy.result = RES_MID;
          end else if (sy_ff.chan == CODE_TST_LOW) begin
            nxt_sy.result = RES_LOW;
          end else if (sy_ff.chan == CODE_TST_HIGH) begin
            nxt_sy.result = RES_HIGH;
          end else begin
            nxt_sy.result = RES_RESET;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sy_ff         <= '0;
      sy_ff.cs_s1   <= 1'b1;
      sy_ff.cs_s2   <= 1'b1;
      sy_ff.eoc     <= 1'b1;
      sy_ff.state   <= ST_IDLE;
      sy_ff.result  <= RES_RESET;
    end else begin
      sy_ff <= nxt_sy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_oe    = sy_ff.oe;
  assign eoc        = sy_ff.eoc;
  assign sample_en  = lk_ff.sample;
  assign chan_sel   = sy_ff.chan;
  assign chan_valid = sy_ff.chan_ok;

endmodule

// File: adc_serial_ctl_properties.sv
module adc_serial_ctl_chk
  import adc_ctl_pkg::*;
(
  // system
  input wire logic              clk,
  input wire logic              rst_b,
  // link and converter
  input wire logic              cs_n,
  input wire logic              data_out,
  input wire logic              data_oe,
  input wire logic              eoc,
  input wire logic              sample_en,
  input wire logic [ADDR_W-1:0] chan_sel,
  input wire logic              chan_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // conversion length counter
  // ----------------------------------------------------------------
  logic [9:0] low_cnt_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) low_cnt_ff <= 10'h000;
    else low_cnt_ff <= eoc ? 10'h000 : low_cnt_ff + 10'h001;
  end

  // tenth falling edge seen while idle and selected
  sequence s_start;
    $fell(sample_en) && !cs_n && eoc;
  endsequence

  AST_OE_OFF: assert property (cs_n [*4] |-> !data_oe)
    else $error("data_oe high with select released");
  AST_OE_ON: assert property ((!cs_n) [*4] |-> data_oe)
    else $error("data_oe low with select active");
  AST_START: assert property (s_start |-> ##[1:8] !eoc)
    else $error("eoc did not fall after tenth edge");
  AST_NO_EARLY: assert property (sample_en |-> eoc)
    else $error("conversion running during sampling");
  AST_CONV_LEN: assert property ($rose(eoc) |-> low_cnt_ff inside {[CONV_CYC-1:CONV_CYC+1]})
    else $error("eoc low for wrong number of cycles");
  AST_IGNORE: assert property (cs_n [*2] |-> !sample_en)
    else $error("sampling with select released");
  AST_ZERO: assert property (s_start |-> (!data_out) [*3])
    else $error("data_out not zero after tenth edge");
  AST_CHAN: assert property (!eoc && !$past(eoc) |-> chan_valid == (chan_sel <= CODE_TST_HIGH))
    else $error("chan_valid disagrees with chan_sel");
endmodule

// File: adc_host_model.sv
module adc_host_model (
  // serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      addr_in,
  input  wire logic data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // shift clock stands still low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    addr_in = 1'b0;
  end

  task automatic frame(input logic [3:0] a, input int n, input bit keep, output logic [15:0] rx,
                       input int pause_at);
    rx = 16'h0000;
    if (!keep) begin
      cs_n = 1'b0;
      #200;
    end
    for (int i = 0; i < n; i++) begin
      // slow transfer: clock stands low while the conversion runs
      if (pause_at > 0 && i == pause_at) #25000;
      // address bits msb first, then a toggling don't-care
      addr_in = (i < 4) ? a[3 - i] : ~addr_in;
      #7.5 sclk = 1'b1;
      rx[15 - i] = data_out;
      #7.5 sclk = 1'b0;
    end
    addr_in = ~addr_in;
    #400;
  endtask

  task automatic release_cs();
    cs_n = 1'b1;
    #200;
  endtask
endmodule

// File: test_adc_serial_ctl.sv
module test_adc_serial_ctl;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctl_pkg::*;

  logic              clk;
  logic              rst_b;
  logic              sclk;
  logic              cs_n;
  logic              addr_in;
  logic              data_out;
  logic              data_pin;
  logic              data_oe;
  logic              eoc;
  logic              sample_en;
  logic              chan_valid;
  logic [RES_W-1:0]  conv_code;
  logic [RES_W-1:0]  prev;
  logic [ADDR_W-1:0] chan_sel;
  logic [15:0]       rx;
  int                err_count;
  int                n_tests;

  adc_serial_ctl u_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .addr_in(addr_in),
    .data_out(data_out), .data_oe(data_oe), .conv_code(conv_code), .eoc(eoc),
    .sample_en(sample_en), .chan_sel(chan_sel), .chan_valid(chan_valid));
  adc_host_model u_host (.sclk(sclk), .cs_n(cs_n), .addr_in(addr_in), .data_out(data_pin));

  // released pin has no pull: show the inverse so a read without enable fails
  assign data_pin = data_oe ? data_out : ~data_out;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [RES_W-1:0] res_of(input logic [3:0] a, input logic [RES_W-1:0] c);
    case (a)
      CODE_TST_MID: return RES_MID;
      CODE_TST_LOW: return RES_LOW;
      CODE_TST_HIGH: return RES_HIGH;
      4'hE, 4'hF: return RES_RESET;
      default: return c;
    endcase
  endfunction

  // bounded wait: a hung conversion ends the run
  task automatic wait_eoc();
    for (int i = 0; i < 1000 && eoc !== 1'b1; i++) @(negedge clk);
    if (eoc !== 1'b1) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic step(input logic [3:0] a, input int n, input bit keep);
    @(negedge clk);
    conv_code = {a, 6'h2B};
    u_host.frame(a, n, keep, rx, 0);
    check("rx", rx, {prev, 6'h00});
    check("eoc_low", {15'h0, eoc}, 16'h0000);
    check("oe_on", {15'h0, data_oe}, 16'h0001);
    wait_eoc();
    check("chan", {11'h0, chan_valid, chan_sel}, {11'h0, a <= 4'hD, a});
    prev = res_of(a, conv_code);
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // select high between frames, 10 to 16 clocks, every test code
  task automatic s_mode1();
    logic [3:0] a [6] = '{4'hD, 4'hB, 4'h5, 4'hF, 4'hC, 4'h0};
    int         n [6] = '{10, 16, 12, 11, 13, 10};
    for (int i = 0; i < 6; i++) begin
      step(a[i], n[i], 1'b0);
      u_host.release_cs();
      check("oe_off", {15'h0, data_oe}, 16'h0000);
    end
  endtask

  // select held low: 10-clock then 16-clock transfers
  task automatic s_mode2();
    step(4'hD, 10, 1'b0);
    check("msb_at_eoc", {15'h0, data_out}, 16'h0001);
    step(4'h5, 10, 1'b1);
    step(4'hC, 16, 1'b1);
    u_host.release_cs();
  endtask

  // select low, 16 clocks, conversion ends between the 11th rise and 16th fall
  task automatic s_mode6();
    @(negedge clk);
    conv_code = 10'h2A5;
    u_host.frame(4'h3, 16, 1'b0, rx, 11);
    check("rx_slow", rx, {prev, 6'h00});
    check("eoc_slow", {15'h0, eoc}, 16'h0001);
    check("msb_at_16th", {15'h0, data_out}, {15'h0, conv_code[RES_W-1]});
    prev = conv_code;
    @(negedge clk);
    u_host.frame(4'hB, 16, 1'b1, rx, 11);
    check("rx_slow_held", rx, {prev, 6'h00});
    check("chan_slow", {11'h0, chan_valid, chan_sel}, {11'h0, 1'b1, CODE_TST_MID});
    prev = RES_MID;
    u_host.release_cs();
  endtask

  initial begin
    rst_b = 1'b0;
    conv_code = 10'h000;
    prev = RES_RESET;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check("idle", {14'h0, data_oe, eoc}, 16'h0001);
    s_mode1();
    s_mode2();
    s_mode6();
    complete_run();
  end
endmodule

bind adc_serial_ctl adc_serial_ctl_chk u_chk (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .data_out(data_out),
  .data_oe(data_oe), .eoc(eoc), .sample_en(sample_en), .chan_sel(chan_sel), .chan_valid(chan_valid));
